/* rtl/eight_bit_wrap_timer.sv */
/*
 * eight bit up-counting timer with programmable wrap limit, four clock
 * sources, power-of-two prescaler, overflow flag and interrupt request.
 * assumes one 100 mhz clock, a single ahb-lite master, and that the fixed
 * frequency clock and the external pin are asynchronous levels.
 */
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
// Function
// RULE1 - count register reads current 8-bit value, ignores writes, resets to zero
// RULE2 - wrap limit zero means free-running; wrap limit resets to zero
// RULE3 - any write to wrap limit clears counter and overflow flag
// RULE4 - after reset: stopped at zero, limit zero, bus clock, divide by one
// RULE5 - modes are stopped, free-running, and wrap-limited
// RULE6 - clock select picks bus, fixed clock, pin rising or falling
// RULE7 - changing clock source keeps the count
// RULE8 - prescaler divides by 1 to 256 in powers of two
// RULE9 - changing prescale keeps the count
// RULE10 - counter steps per tick up to limit, then wraps to zero
// RULE11 - overflow flag sets on each limit-to-zero transition
// RULE12 - flag cleared by reading status while set, then writing zero
// RULE13 - rollover between read and write cancels the pending clear
// RULE14 - writing one to counter reset clears overflow flag
// RULE15 - interrupt asserted while flag set and enable is one
// RULE16 - software should clear flag before enabling the interrupt
// RULE17 - wrap limit accepts any value from one to 255
// RULE18 - stop bit freezes count, clearing resumes; reset sets stop
// RULE19 - counter reset bit forces zero on one, reads zero
// RULE20 - clock select 00 bus, 01 fixed, 10 pin fall, 11 pin rise
// RULE21 - prescale 0 to 8 select 1 to 256; higher gives 256
// RULE22 - pin synchronised, selected edge gives one-cycle count enable
`timescale 1ns/100ps
module eight_bit_wrap_timer (
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic FIXED_FREQ_CLOCK_I,
   input wire logic EXT_CLOCK_PIN_I,
   output logic IRQ_O
);
   import wrap_timer_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bus_access_t acc;
   logic [7:0] timer_count_value;
   logic [7:0] wrap_limit;
   logic overflow_flag;
   logic overflow_irq_enable;
   logic stop_bit;
   logic [1:0] clock_select;
   logic [3:0] prescale_select;
   logic clear_armed;
   logic [2:0] fix_sync;
   logic [2:0] pin_sync;
   logic [7:0] prescaler;
   logic src_tick;
   logic tick;
   logic rollover;
   logic wr_status;
   logic wr_clock;
   logic wr_wrap;
   logic rd_status;
   logic cnt_reset_req;

   // prescale mask: bits of the prescaler that must be all ones for a tick
   function automatic logic [7:0] prescale_mask(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > PRESCALE_MAX) ? PRESCALE_MAX : sel; // RULE21
      prescale_mask = 8'((9'h001 << s) - 9'h001); // RULE8
   endfunction : prescale_mask

   // ----------------------------------------------------------------
   // ahb-lite slave: zero wait state, always okay
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         acc <= '0;
      end else if (HREADY_I) begin
         acc.valid <= HSEL_I & HTRANS_I[1];
         acc.write <= HWRITE_I;
         acc.addr <= HADDR_I[7:0];
      end
   end

   assign wr_status = acc.valid & acc.write & (acc.addr == STATUS_CONTROL_OFS);
   assign wr_clock = acc.valid & acc.write & (acc.addr == CLOCK_CONFIG_OFS);
   assign wr_wrap = acc.valid & acc.write & (acc.addr == WRAP_LIMIT_OFS);
   assign rd_status = HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I &
                      (HADDR_I[7:0] == STATUS_CONTROL_OFS);
   assign cnt_reset_req = wr_status & HWDATA_I[CNT_RST_BIT]; // RULE19

   // read data registered in the address phase
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         HRDATA_O <= '0;
      end else if (HSEL_I & HREADY_I & HTRANS_I[1] & ~HWRITE_I) begin
         unique case (HADDR_I[7:0])
            STATUS_CONTROL_OFS: HRDATA_O <= {24'h0, overflow_flag, overflow_irq_enable,
                                             1'b0, stop_bit, 4'h0}; // RULE19
            CLOCK_CONFIG_OFS: HRDATA_O <= {24'h0, 2'b00, clock_select, prescale_select};
            COUNT_VALUE_OFS: HRDATA_O <= {24'h0, timer_count_value}; // RULE1
            WRAP_LIMIT_OFS: HRDATA_O <= {24'h0, wrap_limit};
            default: HRDATA_O <= '0;
         endcase
      end
   end

   // ready and response never change
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end else begin
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         overflow_irq_enable <= 1'b0;
         stop_bit <= STOP_RESET; // RULE18 RULE4
      end else if (wr_status) begin
         overflow_irq_enable <= HWDATA_I[IRQ_EN_BIT];
         stop_bit <= HWDATA_I[STOP_BIT];
      end
   end

   // clock source and prescale; writes leave the count alone
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         clock_select <= SRC_BUS; // RULE4
         prescale_select <= PRESCALE_RESET;
      end else if (wr_clock) begin
         clock_select <= HWDATA_I[CLK_SEL_LSB +: 2]; // RULE7
         prescale_select <= HWDATA_I[PRESCALE_LSB +: 4]; // RULE9
      end
   end

   // wrap limit takes any byte value
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         wrap_limit <= WRAP_RESET; // RULE2
      end else if (wr_wrap) begin
         wrap_limit <= HWDATA_I[7:0]; // RULE17
      end
   end

   // ----------------------------------------------------------------
   // clock sources: synchronisers and edge detect
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         fix_sync <= '0;
         pin_sync <= '0;
      end else begin
         fix_sync <= {fix_sync[1:0], FIXED_FREQ_CLOCK_I};
         pin_sync <= {pin_sync[1:0], EXT_CLOCK_PIN_I}; // RULE22
      end
   end

   // source tick selection, one cycle per qualifying edge
   always_comb begin
      unique case (clk_src_t'(clock_select)) // RULE6 RULE20
         SRC_BUS: src_tick = 1'b1;
         SRC_FIXED: src_tick = fix_sync[1] & ~fix_sync[2];
         SRC_EXT_FALL: src_tick = ~pin_sync[1] & pin_sync[2]; // RULE22
         SRC_EXT_RISE: src_tick = pin_sync[1] & ~pin_sync[2]; // RULE22
      endcase
   end

   // ----------------------------------------------------------------
   // prescaler: counter of source ticks, cleared by stop, wrap write or counter reset; tick when low bits all ones
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         prescaler <= '0;
      end else if (stop_bit | wr_wrap | cnt_reset_req) begin
         prescaler <= '0;
      end else if (src_tick) begin
         prescaler <= prescaler + 8'h01;
      end
   end

   assign tick = ~stop_bit & src_tick &
                 ((prescaler & prescale_mask(prescale_select)) ==
                  prescale_mask(prescale_select)); // RULE8 RULE18
   // free-running limit zero rolls at 8'hff
   assign rollover = tick & (wrap_limit == 8'h00 ? timer_count_value == 8'hff :
                             timer_count_value == wrap_limit); // RULE5 RULE11

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         timer_count_value <= COUNT_RESET; // RULE1 RULE4
      end else if (wr_wrap | cnt_reset_req) begin
         timer_count_value <= COUNT_RESET; // RULE3 RULE19
      end else if (rollover) begin
         timer_count_value <= COUNT_RESET; // RULE10 RULE2
      end else if (tick) begin
         timer_count_value <= timer_count_value + 8'h01; // RULE10
      end
   end

   // ----------------------------------------------------------------
   // overflow flag with two-step clear
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         clear_armed <= 1'b0;
      end else if (rollover) begin
         clear_armed <= 1'b0; // RULE13
      end else if (rd_status & overflow_flag) begin
         clear_armed <= 1'b1; // RULE12
      end else if (wr_status) begin
         clear_armed <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         overflow_flag <= 1'b0;
      end else if (wr_wrap | cnt_reset_req) begin
         overflow_flag <= 1'b0; // RULE3 RULE14
      end else if (rollover) begin
         overflow_flag <= 1'b1; // RULE11 RULE13
      end else if (wr_status & clear_armed & ~HWDATA_I[OVF_BIT]) begin
         overflow_flag <= 1'b0; // RULE12
      end
   end

   // interrupt request, registered
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_B_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= overflow_flag & overflow_irq_enable; // RULE15
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_count_reset;
      @(posedge REF_CLK_I) !RST_B_I |=> timer_count_value == 8'h00 && stop_bit;
   endproperty
   a_count_reset: assert property (p_count_reset) // RULE1
      else $error("count not zero after reset");

   property p_wrap_write_clears;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         wr_wrap |=> timer_count_value == 8'h00 && !overflow_flag;
   endproperty
   a_wrap_write_clears: assert property (p_wrap_write_clears) // RULE3
      else $error("wrap write no clear");

   property p_stop_freezes;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         stop_bit && !wr_wrap && !cnt_reset_req |=> $stable(timer_count_value);
   endproperty
   a_stop_freezes: assert property (p_stop_freezes) // RULE18
      else $error("count moved while stopped");

   property p_rollover_sets;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         rollover && !wr_wrap && !cnt_reset_req |=> overflow_flag && timer_count_value == 8'h00;
   endproperty
   a_rollover_sets: assert property (p_rollover_sets) // RULE11
      else $error("rollover did not set flag");

   property p_step;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         tick && !rollover && !wr_wrap && !cnt_reset_req |=>
            timer_count_value == $past(timer_count_value) + 8'h01;
   endproperty
   a_step: assert property (p_step) // RULE10
      else $error("count did not step");

   property p_pending_cancel;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         rollover |=> !clear_armed;
   endproperty
   a_pending_cancel: assert property (p_pending_cancel) // RULE13
      else $error("clear not cancelled");

   property p_trst_clears;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         cnt_reset_req |=> !overflow_flag && timer_count_value == 8'h00;
   endproperty
   a_trst_clears: assert property (p_trst_clears) // RULE14
      else $error("counter reset failed");

   property p_irq;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         ##1 IRQ_O == $past(overflow_flag & overflow_irq_enable);
   endproperty
   a_irq: assert property (p_irq) // RULE15
      else $error("irq mismatch");

   property p_no_limit_exceed;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         wrap_limit != 8'h00 && tick && timer_count_value == wrap_limit |=>
            timer_count_value == 8'h00;
   endproperty
   a_no_limit_exceed: assert property (p_no_limit_exceed) // RULE17
      else $error("limit passed");

   // a status write without a qualifying read or the counter reset bit leaves the flag alone
   property p_clear_needs_read;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         wr_status && !clear_armed && !cnt_reset_req && overflow_flag |=> overflow_flag;
   endproperty
   a_clear_needs_read: assert property (p_clear_needs_read) // RULE12
      else $error("flag cleared without read");

   // the write-only counter reset bit never shows in status read data
   property p_reset_bit_reads_zero;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         rd_status |=> HRDATA_O[CNT_RST_BIT] == 1'b0;
   endproperty
   a_reset_bit_reads_zero: assert property (p_reset_bit_reads_zero) // RULE19
      else $error("counter reset bit read as one");

   // a pin or fixed clock edge gives one enable, never two in a row
   property p_single_edge;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         src_tick && clock_select != SRC_BUS ##1 $stable(clock_select) |-> !src_tick;
   endproperty
   a_single_edge: assert property (p_single_edge) // RULE22
      else $error("source enable longer than one cycle");

   // clock and prescale writes keep the count moving from where it was
   property p_clock_write_keeps;
      @(posedge REF_CLK_I) disable iff (!RST_B_I)
         wr_clock && !rollover |=>
            timer_count_value == $past(timer_count_value) + 8'($past(tick));
   endproperty
   a_clock_write_keeps: assert property (p_clock_write_keeps) // RULE9
      else $error("clock write disturbed count");

   c_rollover: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I) rollover);
   c_two_step: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      clear_armed ##[1:20] !overflow_flag);
   c_ext_tick: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
      tick && clock_select == SRC_EXT_RISE);
   c_irq: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I) IRQ_O);

endmodule : eight_bit_wrap_timer

/* shared/wrap_timer_pkg.sv */
/*
 * package for the eight bit wrap timer: register offsets, field positions,
 * reset values, clock source encodings and the register-access struct.
 * assumes a 32-bit ahb-lite bus with word-aligned registers.
 */
package wrap_timer_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] STATUS_CONTROL_OFS = 8'h00;
   localparam logic [7:0] CLOCK_CONFIG_OFS = 8'h04;
   localparam logic [7:0] COUNT_VALUE_OFS = 8'h08;
   localparam logic [7:0] WRAP_LIMIT_OFS = 8'h0c;

   // ----------------------------------------------------------------
   // field positions in status_control_reg
   // ----------------------------------------------------------------
   localparam int OVF_BIT = 7;
   localparam int IRQ_EN_BIT = 6;
   localparam int CNT_RST_BIT = 5;
   localparam int STOP_BIT = 4;
   // clock config fields
   localparam int CLK_SEL_LSB = 4;
   localparam int PRESCALE_LSB = 0;

   // ----------------------------------------------------------------
   // reset values and limits
   // ----------------------------------------------------------------
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] WRAP_RESET = 8'h00;
   localparam logic [3:0] PRESCALE_RESET = 4'h0;
   localparam logic [3:0] PRESCALE_MAX = 4'h8;
   localparam logic STOP_RESET = 1'b1;

   // clock source encodings
   typedef enum logic [1:0] {
      SRC_BUS = 2'h0,
      SRC_FIXED = 2'h1,
      SRC_EXT_FALL = 2'h2,
      SRC_EXT_RISE = 2'h3
   } clk_src_t;

   // one decoded bus access, captured in the address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } bus_access_t;

endpackage : wrap_timer_pkg

/* verification/eight_bit_wrap_timer_tb_top.sv */
/*
 * self-checking bench for the eight bit wrap timer: register rows, counting,
 * clock sources, prescaler, wrap, overflow clear and interrupt.
 * assumes the zero-wait ahb-lite slave and the map of wrap_timer_pkg.
 */
`timescale 1ns/100ps
module eight_bit_wrap_timer_tb_top;
   import wrap_timer_pkg::*;
   typedef struct packed {logic wr; logic [7:0] ad; logic [31:0] wd; logic [31:0] ex;} row_t;
   logic clk, rst_b, hsel, hwrite, fix_clk, ext_pin, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, a, b, c;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int mismatches, check_count, cycles;
   int ps_enc[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 15};
   int src_enc[3] = '{1, 3, 2};
   // reset values first, then accepted, refused and masked accesses
   row_t rows[18] = '{
      '{1'b0, STATUS_CONTROL_OFS, 32'h0, 32'h10}, '{1'b0, CLOCK_CONFIG_OFS, 32'h0, 32'h0},
      '{1'b0, COUNT_VALUE_OFS, 32'h0, 32'h0}, '{1'b0, WRAP_LIMIT_OFS, 32'h0, 32'h0},
      '{1'b1, COUNT_VALUE_OFS, 32'h55, 32'h0}, '{1'b0, COUNT_VALUE_OFS, 32'h0, 32'h0},
      '{1'b1, WRAP_LIMIT_OFS, 32'hff, 32'h0}, '{1'b0, WRAP_LIMIT_OFS, 32'h0, 32'hff},
      '{1'b1, WRAP_LIMIT_OFS, 32'h01, 32'h0}, '{1'b0, WRAP_LIMIT_OFS, 32'h0, 32'h01},
      '{1'b1, CLOCK_CONFIG_OFS, 32'h3f, 32'h0}, '{1'b0, CLOCK_CONFIG_OFS, 32'h0, 32'h3f},
      '{1'b1, CLOCK_CONFIG_OFS, 32'h0, 32'h0}, '{1'b1, 8'h40, 32'hff, 32'h0},
      '{1'b0, 8'h40, 32'h0, 32'h0}, '{1'b1, STATUS_CONTROL_OFS, 32'h30, 32'h0},
      '{1'b0, STATUS_CONTROL_OFS, 32'h0, 32'h10}, '{1'b1, WRAP_LIMIT_OFS, 32'h0, 32'h0}};

   eight_bit_wrap_timer eight_bit_wrap_timer_i (.REF_CLK_I(clk), .RST_B_I(rst_b),
      .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
      .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout),
      .HRESP_O(hresp), .FIXED_FREQ_CLOCK_I(fix_clk), .EXT_CLOCK_PIN_I(ext_pin), .IRQ_O(irq));

   // ----------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // a stuck handshake ends the run as a failure
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // bus and compare tasks
   // ----------------------------------------------------------------
   task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, ad};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      logic [31:0] d;
      xfer(1'b1, ad, wd, d);
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      xfer(1'b0, ad, 32'h0, d);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic chk_flag(input string nm, input logic ex, input logic got);
      chk(nm, {31'h0, ex}, {31'h0, got});
   endtask : chk_flag
   task automatic run_rows(input int lo, input int hi);
      logic [31:0] d;
      for (int i = lo; i <= hi; i++) begin
         xfer(rows[i].wr, rows[i].ad, rows[i].wd, d);
         if (!rows[i].wr) chk("row", rows[i].ex, d);
      end
   endtask : run_rows
   // five toggles of one pin, four cycles apart
   task automatic toggle(input logic on_ext);
      repeat (5) begin
         if (on_ext) ext_pin <= ~ext_pin;
         else fix_clk <= ~fix_clk;
         idle(4);
      end
   endtask : toggle
   task automatic wrap_up;
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      {rst_b, hsel, hwrite, fix_clk, ext_pin, htrans} = '0;
      {haddr, hwdata, mismatches, check_count} = '0;
      hsize = 3'h2;
      idle(5);
      rst_b <= 1'b1;
      run_rows(0, 17);
      wr(STATUS_CONTROL_OFS, 32'h00);
      rd(COUNT_VALUE_OFS, a);
      idle(298);
      rd(COUNT_VALUE_OFS, b);
      chk("free_run", {24'h0, a[7:0] + 8'd44}, b);
      wr(STATUS_CONTROL_OFS, 32'h10);
      rd(COUNT_VALUE_OFS, a);
      idle(10);
      rd(COUNT_VALUE_OFS, b);
      chk("stopped", a, b);
      wr(STATUS_CONTROL_OFS, 32'h00);
      idle(8);
      rd(COUNT_VALUE_OFS, c);
      chk("resumed", {24'h0, a[7:0] + 8'd8}, c);
      // prescale encodings 0 to 9 and 15 while running, four ticks per window
      foreach (ps_enc[i]) begin
         wr(CLOCK_CONFIG_OFS, ps_enc[i]);
         rd(COUNT_VALUE_OFS, a);
         idle(4 * (1 << (ps_enc[i] > 8 ? 8 : ps_enc[i])) - 2);
         rd(COUNT_VALUE_OFS, b);
         chk("prescale", {24'h0, a[7:0] + 8'd4}, b);
      end
      wr(CLOCK_CONFIG_OFS, 32'h00);
      rd(COUNT_VALUE_OFS, a);
      wr(CLOCK_CONFIG_OFS, 32'h10);
      rd(COUNT_VALUE_OFS, b);
      chk("src_kept", {24'h0, a[7:0] + 8'd4}, b);
      // three edges of the selected source, none of the other pin
      foreach (src_enc[i]) begin
         wr(CLOCK_CONFIG_OFS, src_enc[i] << CLK_SEL_LSB);
         rd(COUNT_VALUE_OFS, a);
         toggle(src_enc[i] != 1);
         idle(6);
         rd(COUNT_VALUE_OFS, b);
         chk("source", {24'h0, a[7:0] + 8'd3}, b);
      end
      wr(CLOCK_CONFIG_OFS, 32'h00);
      wr(WRAP_LIMIT_OFS, 32'h03);
      idle(10);
      rd(COUNT_VALUE_OFS, a);
      idle(3);
      rd(COUNT_VALUE_OFS, b);
      chk_flag("limited", 1'b1, a[7:0] <= 8'd3);
      chk("wrap", {30'h0, a[1:0] + 2'd1}, b);
      rd(STATUS_CONTROL_OFS, c);
      chk_flag("ovf_set", 1'b1, c[OVF_BIT]);
      chk_flag("irq_off", 1'b0, irq);
      // a rollover falls between the arming read and the stopping write
      idle(4);
      wr(STATUS_CONTROL_OFS, 32'h10);
      rd(STATUS_CONTROL_OFS, c);
      chk_flag("clear_lost", 1'b1, c[OVF_BIT]);
      // writing one to the flag disarms, then a bare write must not clear
      wr(STATUS_CONTROL_OFS, 32'h90);
      wr(STATUS_CONTROL_OFS, 32'h10);
      rd(STATUS_CONTROL_OFS, c);
      chk_flag("no_arm", 1'b1, c[OVF_BIT]);
      wr(STATUS_CONTROL_OFS, 32'h10);
      rd(STATUS_CONTROL_OFS, c);
      chk("cleared", 32'h10, c);
      wr(STATUS_CONTROL_OFS, 32'h00);
      idle(8);
      wr(STATUS_CONTROL_OFS, 32'h30);
      rd(STATUS_CONTROL_OFS, c);
      chk("cnt_reset", 32'h10, c);
      rd(COUNT_VALUE_OFS, c);
      chk("cnt_zero", 32'h0, c);
      wr(STATUS_CONTROL_OFS, 32'h00);
      idle(8);
      wr(WRAP_LIMIT_OFS, 32'h05);
      wr(STATUS_CONTROL_OFS, 32'h10);
      rd(STATUS_CONTROL_OFS, c);
      chk("wrap_wr", 32'h10, c);
      rd(COUNT_VALUE_OFS, c);
      chk("wrap_cnt", 32'h2, c);
      wr(STATUS_CONTROL_OFS, 32'h40);
      idle(10);
      chk_flag("irq_on", 1'b1, irq);
      wr(STATUS_CONTROL_OFS, 32'h70);
      idle(2);
      chk_flag("irq_gone", 1'b0, irq);
      // second reset in mid-run restores every field
      wr(CLOCK_CONFIG_OFS, 32'h25);
      wr(WRAP_LIMIT_OFS, 32'h07);
      rst_b <= 1'b0;
      idle(3);
      rst_b <= 1'b1;
      run_rows(0, 3);
      wrap_up();
   end
endmodule : eight_bit_wrap_timer_tb_top
